// >>> src/pin_mux_regs.svh
// register offsets, field positions, reset values and timing counts of the pin mux
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SYSCFG_OFFSET 12'h000
`define PPCYC_OFFSET 12'h004
`define PPADDR_OFFSET 12'h008
`define PPDATA_OFFSET 12'h00C
`define FLAGOUT_OFFSET 12'h010
`define FLAGOE_OFFSET 12'h014
`define FLAGIN_OFFSET 12'h018
`define STATUS_OFFSET 12'h01C

// ----------------------------------------
// system config fields
// ----------------------------------------
`define PP_DIS_BIT 20
`define FLAG_SEL_LSB 22
`define FLAG_SEL_W 4
`define PP_MODE16_BIT 0
`define SYSCFG_RESET 32'h0000_0000

// ----------------------------------------
// cycle control fields
// ----------------------------------------
`define PP_START_BIT 0
`define PP_WRITE_BIT 1
`define ALE_CYC_RESET 8'h02
`define DATA_CYC_RESET 8'h04

`endif

// >>> src/pin_mux_pkg.sv
// types shared by the pin mux modules
package pin_mux_pkg;

    typedef enum logic [1:0] {
        PP_IDLE = 2'b00,
        PP_ALE = 2'b01,
        PP_DATA = 2'b10
    } pp_state_t;

endpackage

// >>> src/flag_map.sv
// crossed pin to flag bit mapping, used in both directions
`timescale 1ns/1ps
module flag_map (
    input wire logic [15:0] pin_side,
    output logic [15:0] flag_side
);
    // the swap of halves is its own inverse, so one module serves both ways
    assign flag_side = {pin_side[7:0], pin_side[15:8]};
endmodule

// >>> src/ad_pin_drive.sv
// word selection on the multiplexed address/data pins during a port cycle
`timescale 1ns/1ps
module ad_pin_drive (
    input wire logic mode16,
    input wire logic ale_phase,
    input wire logic [23:0] addr,
    input wire logic [15:0] data,
    output logic [15:0] pin_word
);
    always_comb begin
        if (mode16) begin
            pin_word = ale_phase ? addr[15:0] : data;
        end else begin
            pin_word = ale_phase ? addr[23:8] : {addr[7:0], data[7:0]};
        end
    end
endmodule

// >>> src/addr_data_pin_function_mux.sv
// parallel port / flag function mux for the sixteen address/data pins
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

// Functional notes
// - port disable bit frees the address/data pins for flag use
// - four flag-select bits each hand a pin group to flag use
// - pins 0..7 are flags 8..15, pins 8..15 are flags 0..7
// - 8-bit mode: A23..8 with latch strobe, then A7..0 and D7..0
// - 16-bit mode: A15..0 with latch strobe, then D15..0
// - read, write, latch strobes float only during reset
module addr_data_pin_function_mux
    import pin_mux_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] muxed_addr_data_pins_in,
    output logic [15:0] muxed_addr_data_pins_out,
    output logic [15:0] muxed_addr_data_pins_oe,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic ale_out,
    output logic strobe_oe
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] system_config_reg_ff;
    logic [7:0] ale_cyc_ff;
    logic [7:0] data_cyc_ff;
    logic [23:0] pp_addr_ff;
    logic [15:0] pp_wdata_ff;
    logic [15:0] pp_rdata_ff;
    logic pp_write_ff;
    logic [15:0] flag_out_ff;
    logic [15:0] flag_oe_ff;
    pp_state_t state_ff;
    pp_state_t nxt_state;
    logic [7:0] cnt_ff;

    logic pp_dis;
    logic mode16;
    logic [3:0] flag_sel;
    logic [15:0] flag_pin_en;
    logic [15:0] flag_in;
    logic [15:0] flag_out_pins;
    logic [15:0] flag_oe_pins;
    logic [15:0] pp_word;
    logic wr_acc;
    logic rd_acc;
    logic start_req;
    logic cnt_done;
    logic [23:0] nxt_pp_addr;

    assign pp_dis = system_config_reg_ff[`PP_DIS_BIT];
    assign mode16 = system_config_reg_ff[`PP_MODE16_BIT];
    assign flag_sel = system_config_reg_ff[`FLAG_SEL_LSB +: `FLAG_SEL_W];
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;
    assign cnt_done = (cnt_ff <= 8'h01);
    // the start edge must already show the new address, or the first latch cycle is stale
    assign nxt_pp_addr = start_req ? pwdata[31:8] : pp_addr_ff;
    // a start is refused while disabled, so no memory cycle can run then
    assign start_req = wr_acc & (paddr == `PPADDR_OFFSET) & ~pp_dis
        & pwdata[`PP_START_BIT] & (state_ff == PP_IDLE);

    // each select bit hands four flag bits (one nibble) to flag use
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            flag_pin_en[i] = pp_dis & flag_sel[i / 4];
        end
    end

    // ----------------------------------------
    // flag mapping, both directions
    // ----------------------------------------
    flag_map u_map_in (
        .pin_side(muxed_addr_data_pins_in),
        .flag_side(flag_in)
    );

    flag_map u_map_oe (
        .pin_side(flag_oe_ff & flag_pin_en),
        .flag_side(flag_oe_pins)
    );

    flag_map u_map_out (
        .pin_side(flag_out_ff),
        .flag_side(flag_out_pins)
    );

    ad_pin_drive u_drive (
        .mode16(mode16),
        .ale_phase(nxt_state == PP_ALE),
        .addr(nxt_pp_addr),
        .data(pp_wdata_ff),
        .pin_word(pp_word)
    );

    // ----------------------------------------
    // apb register writes
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_config_reg_ff <= `SYSCFG_RESET;
            ale_cyc_ff <= `ALE_CYC_RESET;
            data_cyc_ff <= `DATA_CYC_RESET;
            pp_wdata_ff <= 16'h0000;
            flag_out_ff <= 16'h0000;
            flag_oe_ff <= 16'h0000;
        end else if (wr_acc) begin
            unique case (paddr)
                `SYSCFG_OFFSET: system_config_reg_ff <= pwdata;
                `PPCYC_OFFSET: begin
                    ale_cyc_ff <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
                    data_cyc_ff <= (pwdata[15:8] == 8'h00) ? 8'h01 : pwdata[15:8];
                end
                `PPDATA_OFFSET: pp_wdata_ff <= pwdata[15:0];
                `FLAGOUT_OFFSET: flag_out_ff <= pwdata[15:0];
                `FLAGOE_OFFSET: flag_oe_ff <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

    // address word and direction are captured with the start command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pp_addr_ff <= 24'h00_0000;
            pp_write_ff <= 1'b0;
        end else if (start_req) begin
            pp_addr_ff <= pwdata[31:8];
            pp_write_ff <= pwdata[`PP_WRITE_BIT];
        end
    end

    // ----------------------------------------
    // port cycle sequencer
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            PP_IDLE: if (start_req) nxt_state = PP_ALE;
            PP_ALE: if (cnt_done) nxt_state = PP_DATA;
            PP_DATA: if (cnt_done) nxt_state = PP_IDLE;
            default: nxt_state = PP_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= PP_IDLE;
            cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == PP_IDLE && nxt_state == PP_ALE) begin
                cnt_ff <= ale_cyc_ff;
            end else if (state_ff == PP_ALE && nxt_state == PP_DATA) begin
                cnt_ff <= data_cyc_ff;
            end else if (!cnt_done) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end

    // read data sampled on the last data cycle of a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pp_rdata_ff <= 16'h0000;
        end else if (state_ff == PP_DATA && cnt_done && !pp_write_ff) begin
            pp_rdata_ff <= mode16 ? muxed_addr_data_pins_in
                : {8'h00, muxed_addr_data_pins_in[7:0]};
        end
    end

    // ----------------------------------------
    // pin and strobe outputs, all registered
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ale_out <= 1'b0;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
            strobe_oe <= 1'b0;
        end else begin
            // strobes stay driven whenever reset is released
            strobe_oe <= 1'b1;
            ale_out <= (nxt_state == PP_ALE) & ~pp_dis;
            rd_n_out <= ~((nxt_state == PP_DATA) & ~pp_write_ff & ~pp_dis);
            wr_n_out <= ~((nxt_state == PP_DATA) & pp_write_ff & ~pp_dis);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            muxed_addr_data_pins_out <= 16'h0000;
            muxed_addr_data_pins_oe <= 16'h0000;
        end else if (pp_dis) begin
            muxed_addr_data_pins_out <= flag_out_pins & flag_oe_pins;
            muxed_addr_data_pins_oe <= flag_oe_pins;
        end else if (nxt_state == PP_ALE || (nxt_state == PP_DATA && pp_write_ff)) begin
            muxed_addr_data_pins_out <= pp_word;
            muxed_addr_data_pins_oe <= 16'hFFFF;
        end else if (nxt_state == PP_DATA && !mode16) begin
            // 8-bit read: the upper pins keep driving the low address byte
            muxed_addr_data_pins_out <= {pp_word[15:8], 8'h00};
            muxed_addr_data_pins_oe <= 16'hFF00;
        end else begin
            muxed_addr_data_pins_out <= 16'h0000;
            muxed_addr_data_pins_oe <= 16'h0000;
        end
    end

    // ----------------------------------------
    // apb read path, zero wait states
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                unique case (paddr)
                    `SYSCFG_OFFSET: prdata <= system_config_reg_ff;
                    `PPCYC_OFFSET: prdata <= {16'h0000, data_cyc_ff, ale_cyc_ff};
                    `PPADDR_OFFSET: prdata <= {pp_addr_ff, 6'h00, pp_write_ff, 1'b0};
                    `PPDATA_OFFSET: prdata <= {pp_rdata_ff, pp_wdata_ff};
                    `FLAGOUT_OFFSET: prdata <= {16'h0000, flag_out_ff};
                    `FLAGOE_OFFSET: prdata <= {16'h0000, flag_oe_ff};
                    `FLAGIN_OFFSET: prdata <= {16'h0000, flag_in};
                    `STATUS_OFFSET: prdata <= {30'h0000_0000, state_ff};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_dis_no_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        $past(pp_dis) |-> (!ale_out && rd_n_out && wr_n_out))
        else $error("strobe asserted while port disabled");

    a_strobe_driven: assert property (@(posedge pclk) disable iff (!presetn)
        $past(presetn) |-> strobe_oe)
        else $error("strobes not driven out of reset");

    a_flag_oe_map: assert property (@(posedge pclk) disable iff (!presetn)
        $past(pp_dis) |-> muxed_addr_data_pins_oe ==
            {$past(flag_oe_ff[7:0] & flag_pin_en[7:0]),
             $past(flag_oe_ff[15:8] & flag_pin_en[15:8])})
        else $error("flag enable mapping wrong");

    a_ale_word16: assert property (@(posedge pclk) disable iff (!presetn)
        (ale_out && mode16) |-> muxed_addr_data_pins_out == pp_addr_ff[15:0])
        else $error("16-bit address phase wrong");

    a_ale_word8: assert property (@(posedge pclk) disable iff (!presetn)
        (ale_out && !mode16) |-> muxed_addr_data_pins_out == pp_addr_ff[23:8])
        else $error("8-bit address phase wrong");

    a_ale_then_data: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ale_out) && !pp_dis |-> (!rd_n_out || !wr_n_out))
        else $error("data phase does not follow latch strobe");

    a_flag_release: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(pp_dis) && $past(flag_pin_en) == 16'h0000) |-> muxed_addr_data_pins_oe == 16'h0000)
        else $error("pins driven with no flag group selected");

    a_start_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        (pp_dis && state_ff == PP_IDLE) |=> state_ff == PP_IDLE)
        else $error("cycle started while port disabled");

    a_wr_word16: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_n_out && $past(mode16)) |-> muxed_addr_data_pins_out == $past(pp_wdata_ff))
        else $error("16-bit write data phase wrong");

    a_wr_word8: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_n_out && !$past(mode16)) |->
            muxed_addr_data_pins_out == {$past(pp_addr_ff[7:0]), $past(pp_wdata_ff[7:0])})
        else $error("8-bit write data phase wrong");

    a_rd_release: assert property (@(posedge pclk) disable iff (!presetn)
        !rd_n_out |-> muxed_addr_data_pins_oe == ($past(mode16) ? 16'h0000 : 16'hFF00))
        else $error("read data phase pin enables wrong");

    a_ale_drive: assert property (@(posedge pclk) disable iff (!presetn)
        ale_out |-> muxed_addr_data_pins_oe == 16'hFFFF)
        else $error("address phase pins not driven");

endmodule

// >>> test/ext_latch_mem.sv
// external address latch and asynchronous memory seen from the shared pins
`timescale 1ns/1ps
module ext_latch_mem (
    input wire logic pclk,
    input wire logic [15:0] pins,
    input wire logic ale,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic strobe_oe,
    output logic [15:0] latch_word,
    output logic [15:0] wr_word,
    output logic [15:0] rd_val,
    output logic rd_en,
    output logic [7:0] ale_cnt
);
    // ----------------------------------------
    // latch and memory
    // ----------------------------------------
    logic ale_q = 1'b0;
    initial latch_word = 16'h0000;
    initial wr_word = 16'h0000;
    initial ale_cnt = 8'h00;
    always @(posedge pclk) begin
        ale_q <= ale && strobe_oe;
        if (strobe_oe && ale) begin
            latch_word <= pins;
        end
        // counts every memory cycle, so a stray one while flags run is seen
        if (strobe_oe && ale && !ale_q) begin
            ale_cnt <= ale_cnt + 8'h01;
        end
        if (strobe_oe && !ale && !wr_n) begin
            wr_word <= pins;
        end
    end
    // memory answers with the last word written, only while read is low
    assign rd_en = strobe_oe && !ale && !rd_n;
    assign rd_val = wr_word;
endmodule

// >>> test/addr_data_pin_function_mux_bench.sv
// self-checking bench of the address/data pin function mux
`timescale 1ns/1ps
`include "pin_mux_regs.svh"
module addr_data_pin_function_mux_bench;
    import pin_mux_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] pins_in, pins_out, pins_oe, ext, latch_word, wr_word, rd_val, flag_val;
    logic rd_n_out, wr_n_out, ale_out, strobe_oe, rd_en, flag_en, e;
    logic [7:0] ale_cnt, cnt0;
    int errors = 0;
    int checks_done = 0;
    // pull-ups hold released pins high
    assign ext = rd_en ? rd_val : (flag_en ? flag_val : 16'hFFFF);
    assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext);
    addr_data_pin_function_mux i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .muxed_addr_data_pins_in(pins_in),
        .muxed_addr_data_pins_out(pins_out), .muxed_addr_data_pins_oe(pins_oe),
        .rd_n_out(rd_n_out), .wr_n_out(wr_n_out), .ale_out(ale_out), .strobe_oe(strobe_oe));
    ext_latch_mem i_mem (.pclk(pclk), .pins(pins_in), .ale(ale_out), .rd_n(rd_n_out),
        .wr_n(wr_n_out), .strobe_oe(strobe_oe), .latch_word(latch_word), .wr_word(wr_word),
        .rd_val(rd_val), .rd_en(rd_en), .ale_cnt(ale_cnt));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task test_done;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        checks_done++;
        if (g !== ex) begin
            errors++;
            $display("FAIL %s expected %h seen %h", nm, ex, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            test_done();
        end
        @(posedge pclk);
    endtask
    task wait_idle;
        int n;
        repeat (2) @(posedge pclk);
        for (n = 0; n < 100; n++) begin
            apb(1'b0, `STATUS_OFFSET, 32'h0);
            if (r[1:0] === PP_IDLE) break;
        end
        if (n >= 100) begin
            errors++;
            test_done();
        end
    endtask
    // ----------------------------------------
    // port cycle table: mode16, write, address, data, latch word, data word
    // ----------------------------------------
    typedef struct {logic m16; logic w; logic [23:0] a; logic [15:0] d;
        logic [15:0] xl; logic [15:0] xd;} row_t;
    row_t rows [5] = '{
        '{1'b0, 1'b1, 24'hABCDEF, 16'h0012, 16'hABCD, 16'hEF12},
        '{1'b0, 1'b1, 24'h000001, 16'h77FF, 16'h0000, 16'h01FF},
        '{1'b1, 1'b1, 24'h5A1234, 16'hBEEF, 16'h1234, 16'hBEEF},
        '{1'b1, 1'b0, 24'h00F00F, 16'h0000, 16'hF00F, 16'hBEEF},
        '{1'b0, 1'b0, 24'h3C5A96, 16'h0000, 16'h3C5A, 16'h00EF}};
    initial begin
        {psel, penable, pwrite, paddr, pwdata, flag_en, flag_val} = '0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        chk("strobe_oe in reset", 32'h0, {31'h0, strobe_oe});
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("strobe_oe after reset", 32'h1, {31'h0, strobe_oe});
        apb(1'b0, `PPCYC_OFFSET, 32'h0);
        chk("cycle lengths", {16'h0, `DATA_CYC_RESET, `ALE_CYC_RESET}, r);
        foreach (rows[i]) begin
            apb(1'b1, `SYSCFG_OFFSET, {31'h0, rows[i].m16});
            apb(1'b1, `PPDATA_OFFSET, {16'h0, rows[i].d});
            apb(1'b1, `PPADDR_OFFSET, {rows[i].a, 6'h00, rows[i].w, 1'b1});
            wait_idle();
            chk("latch word", {16'h0, rows[i].xl}, {16'h0, latch_word});
            if (rows[i].w) begin
                chk("data word", {16'h0, rows[i].xd}, {16'h0, wr_word});
            end else begin
                apb(1'b0, `PPDATA_OFFSET, 32'h0);
                chk("read word", {16'h0, rows[i].xd}, {16'h0, r[31:16]});
            end
        end
        chk("memory cycles", 32'h5, {24'h0, ale_cnt});
        // awkward cases: unmapped place, flag groups, blocked start, flag in
        apb(1'b1, 12'h020, 32'h0);
        chk("pslverr unmapped", 32'h1, {31'h0, e});
        apb(1'b1, `SYSCFG_OFFSET, 32'h0050_0000);
        apb(1'b1, `FLAGOE_OFFSET, 32'h0000_FFFF);
        apb(1'b1, `FLAGOUT_OFFSET, 32'h0000_00A5);
        repeat (2) @(posedge pclk);
        chk("oe group0", 32'h0F00, {16'h0, pins_oe});
        chk("pins group0", 32'h5, {28'h0, pins_out[11:8]});
        apb(1'b1, `SYSCFG_OFFSET, 32'h03D0_0000);
        repeat (2) @(posedge pclk);
        chk("oe all groups", 32'hFFFF, {16'h0, pins_oe});
        chk("pins all groups", 32'hA500, {16'h0, pins_out});
        cnt0 = ale_cnt;
        apb(1'b1, `PPADDR_OFFSET, 32'h1234_5603);
        repeat (12) @(posedge pclk);
        chk("cycles while disabled", {24'h0, cnt0}, {24'h0, ale_cnt});
        chk("strobes idle", 32'h6, {29'h0, rd_n_out, wr_n_out, ale_out});
        apb(1'b1, `FLAGOE_OFFSET, 32'h0);
        flag_en <= 1'b1;
        flag_val <= 16'h1234;
        repeat (2) @(posedge pclk);
        apb(1'b0, `FLAGIN_OFFSET, 32'h0);
        chk("flag in", 32'h3412, {16'h0, r[15:0]});
        presetn <= 1'b0;
        #3;
        chk("strobe_oe second reset", 32'h0, {31'h0, strobe_oe});
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("strobe_oe driven again", 32'h1, {31'h0, strobe_oe});
        test_done();
    end
endmodule
